// ### dma_ctx_pkg.sv
package dma_ctx_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_AREQ_PTR   = 12'h19C;
   localparam logic [11:0] ADDR_ARSP_PTR   = 12'h1AC;
   localparam logic [11:0] ADDR_ARRQ_PTR   = 12'h1CC;
   localparam logic [11:0] ADDR_ARRS_PTR   = 12'h1EC;
   localparam logic [11:0] ADDR_IT_SET     = 12'h200;
   localparam logic [11:0] ADDR_IT_CLR     = 12'h204;
   localparam logic [11:0] ADDR_IT_PTR     = 12'h20C;
   localparam logic [11:0] ADDR_IT_EVENT   = 12'h208;
   // Control register fields
   localparam int CYC_EN_BIT   = 31;
   localparam int CYC_HI       = 30;
   localparam int CYC_LO       = 16;
   localparam int RUN_BIT      = 15;
   localparam int WAKE_BIT     = 12;
   localparam int DEAD_BIT     = 11;
   localparam int ACTIVE_BIT   = 10;
   localparam int SPEED_HI     = 7;
   localparam int SPEED_LO     = 5;
   localparam int EVT_HI       = 4;
   // Bits software may set or clear
   localparam logic [31:0] SW_MASK = 32'hFFFF_9000;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PTR_RESET  = 32'h0000_0000;
   // Completion codes
   localparam logic [4:0] EVT_ACK_COMPLETE = 5'h11;
   localparam logic [4:0] EVT_DESC_READ    = 5'h06;
   localparam logic [4:0] EVT_DATA_READ    = 5'h07;
   localparam logic [4:0] EVT_UNKNOWN      = 5'h0E;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   typedef enum logic [4:0]
   {
      ST_IDLE  = 5'b00001,
      ST_FETCH = 5'b00010,
      ST_WAITC = 5'b00100,
      ST_XMIT  = 5'b01000,
      ST_HALT  = 5'b10000
   } it_state_t;
endpackage

// ### dma_context_pointer_and_iso_tx_control.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// Functional notes
// - Setting run makes the engine fetch from the context's command pointer.
// - Pointer bits 31-4 hold descriptor address; low four address bits zero.
// - Pointer bits 3-0 give descriptor count; zero means address invalid.
// - Pointer is software read/write and updated by the engine; software writes are ignored while active bit 10 is set.
// - With cycle match on, first packet goes in the matching cycle.
// - Start cycle field bits 30-16: two seconds bits plus 13-bit cycle.
// - Context enabled only when cycle start count equals start cycle.
// - Run bit set/cleared by software; hardware changes it only on reset.
// - Resume bit 12 set by software, cleared on every descriptor fetch.
// - Fatal-halt bit 11 set on fatal error, cleared when run clears.
// - Active bit 10 is high while descriptors are being processed.
// - Reserved bits 14-13 and 9-8 read as zero.
// - Speed code bits 7-5 carry no meaning for transmit; read as zero.
// - Completion code bits 4-0 written after the last output command.
// - Set register at 200h, clear register at 204h for context 0.
module dma_context_pointer_and_iso_tx_control
   import dma_ctx_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        softRst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             fetchReq,
   output logic [31:0]      fetchAddr,
   input  wire logic        fetchAck,
   input  wire logic        fetchErr,
   input  wire logic [31:0] fetchData,
   input  wire logic        fetchLast,
   input  wire logic        cycleStartSeen,
   input  wire logic [14:0] cycleStartValue,
   output logic             pktValid,
   output logic [31:0]      pktData,
   input  wire logic        pktReady,
   input  wire logic        xmitDone,
   input  wire logic        xmitDataErr
);

   logic [31:0] ptrAreq;
   logic [31:0] ptrArsp;
   logic [31:0] ptrArrq;
   logic [31:0] ptrArrs;
   logic [31:0] ptrIt;
   logic [31:0] ctrl;
   it_state_t   state;
   logic [3:0]  descLeft;
   logic [31:0] bufData [2];
   logic        bufWr;
   logic        bufRd;
   logic [1:0]  bufCnt;
   logic        wrPtr;
   logic        rdPtr;
   logic        acc;
   logic        wr;
   logic        runPrev;
   logic        runRise;
   logic        fetchDone;
   logic        rstAny;

   function automatic logic isAddr(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   assign acc     = psel & penable;
   assign wr      = acc & pwrite;
   assign pready  = 1'b1;
   assign rstAny  = softRst;
   assign runRise = ctrl[RUN_BIT] & ~runPrev;
   assign fetchDone = fetchReq & fetchAck;

   // Unmapped address answers with an error
   always_comb
   begin
      pslverr = 1'b0;
      if (acc && !(isAddr(paddr, ADDR_AREQ_PTR) || isAddr(paddr, ADDR_ARSP_PTR)
          || isAddr(paddr, ADDR_ARRQ_PTR) || isAddr(paddr, ADDR_ARRS_PTR)
          || isAddr(paddr, ADDR_IT_SET) || isAddr(paddr, ADDR_IT_CLR)
          || isAddr(paddr, ADDR_IT_PTR)))
      begin
         pslverr = 1'b1;
      end
   end

   // Read data; reserved and speed bits forced to zero
   always_comb
   begin
      prdata = 32'h0000_0000;
      if (isAddr(paddr, ADDR_AREQ_PTR))
      begin
         prdata = ptrAreq;
      end
      else if (isAddr(paddr, ADDR_ARSP_PTR))
      begin
         prdata = ptrArsp;
      end
      else if (isAddr(paddr, ADDR_ARRQ_PTR))
      begin
         prdata = ptrArrq;
      end
      else if (isAddr(paddr, ADDR_ARRS_PTR))
      begin
         prdata = ptrArrs;
      end
      else if (isAddr(paddr, ADDR_IT_PTR))
      begin
         prdata = ptrIt;
      end
      else if (isAddr(paddr, ADDR_IT_SET) || isAddr(paddr, ADDR_IT_CLR))
      begin
         prdata = ctrl & 32'hFFFF_9C1F;
      end
   end

   // Asynchronous context pointers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ptrAreq <= PTR_RESET;
         ptrArsp <= PTR_RESET;
         ptrArrq <= PTR_RESET;
         ptrArrs <= PTR_RESET;
      end
      else if (rstAny)
      begin
         ptrAreq <= PTR_RESET;
         ptrArsp <= PTR_RESET;
         ptrArrq <= PTR_RESET;
         ptrArrs <= PTR_RESET;
      end
      else if (wr)
      begin
         if (isAddr(paddr, ADDR_AREQ_PTR))
         begin
            ptrAreq <= pwdata;
         end
         if (isAddr(paddr, ADDR_ARSP_PTR))
         begin
            ptrArsp <= pwdata;
         end
         if (isAddr(paddr, ADDR_ARRQ_PTR))
         begin
            ptrArrq <= pwdata;
         end
         if (isAddr(paddr, ADDR_ARRS_PTR))
         begin
            ptrArrs <= pwdata;
         end
      end
   end

   // Transmit context pointer: software write, engine advance
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ptrIt <= PTR_RESET;
      end
      else if (rstAny)
      begin
         ptrIt <= PTR_RESET;
      end
      else if (wr && isAddr(paddr, ADDR_IT_PTR) && !ctrl[ACTIVE_BIT])
      begin
         ptrIt <= pwdata;
      end
      else if (fetchDone && !fetchErr && fetchLast)
      begin
         ptrIt <= fetchData;
      end
   end

   // Run edge detect
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         runPrev <= 1'b0;
      end
      else
      begin
         runPrev <= ctrl[RUN_BIT];
      end
   end

   // Control register: software set/clear plus engine updates
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl <= CTRL_RESET;
      end
      else if (rstAny)
      begin
         ctrl <= CTRL_RESET;
      end
      else
      begin
         if (wr && isAddr(paddr, ADDR_IT_SET))
         begin
            ctrl <= ctrl | (pwdata & SW_MASK);
         end
         else if (wr && isAddr(paddr, ADDR_IT_CLR))
         begin
            ctrl <= ctrl & ~(pwdata & SW_MASK);
            if (pwdata[RUN_BIT])
            begin
               ctrl[DEAD_BIT] <= 1'b0;
            end
         end
         // Engine updates win over software writes
         if (state == ST_FETCH && fetchDone)
         begin
            ctrl[WAKE_BIT] <= 1'b0;
         end
         ctrl[ACTIVE_BIT] <= (state == ST_FETCH) || (state == ST_WAITC)
                             || (state == ST_XMIT);
         if (state == ST_FETCH && fetchDone && fetchErr)
         begin
            ctrl[DEAD_BIT] <= 1'b1;
            ctrl[EVT_HI:0] <= EVT_DESC_READ;
         end
         else if (state == ST_XMIT && xmitDataErr)
         begin
            ctrl[DEAD_BIT] <= 1'b1;
            ctrl[EVT_HI:0] <= EVT_DATA_READ;
         end
         else if (state == ST_XMIT && xmitDone && bufCnt == 2'h0)
         begin
            ctrl[EVT_HI:0] <= EVT_ACK_COMPLETE;
         end
         if (state == ST_WAITC && cycleStartSeen
             && cycleStartValue == ctrl[CYC_HI:CYC_LO])
         begin
            ctrl[CYC_EN_BIT] <= 1'b0;
         end
         ctrl[SPEED_HI:SPEED_LO] <= 3'h0;
      end
   end

   // Descriptor engine
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state    <= ST_IDLE;
         descLeft <= 4'h0;
      end
      else if (rstAny || !ctrl[RUN_BIT])
      begin
         state    <= ST_IDLE;
         descLeft <= 4'h0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               if (runRise || ctrl[WAKE_BIT])
               begin
                  if (ptrIt[3:0] != 4'h0)
                  begin
                     descLeft <= ptrIt[3:0];
                     state    <= ST_FETCH;
                  end
               end
            end
            ST_FETCH:
            begin
               if (fetchDone)
               begin
                  if (fetchErr)
                  begin
                     state <= ST_HALT;
                  end
                  else if (fetchLast)
                  begin
                     state <= ctrl[CYC_EN_BIT] ? ST_WAITC : ST_XMIT;
                  end
                  else
                  begin
                     descLeft <= 4'(descLeft - 4'h1);
                  end
               end
            end
            ST_WAITC:
            begin
               if (cycleStartSeen
                   && cycleStartValue == ctrl[CYC_HI:CYC_LO])
               begin
                  state <= ST_XMIT;
               end
            end
            ST_XMIT:
            begin
               if (xmitDataErr)
               begin
                  state <= ST_HALT;
               end
               else if (xmitDone && bufCnt == 2'h0)
               begin
                  // Next pointer was loaded at the last fetch
                  if (ptrIt[3:0] != 4'h0)
                  begin
                     descLeft <= ptrIt[3:0];
                     state    <= ST_FETCH;
                  end
                  else
                  begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_HALT:
            begin
               state <= ST_HALT;
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Descriptor fetch request from the pointer address
   assign fetchReq  = (state == ST_FETCH) && (bufCnt != BUF_DEPTH);
   assign fetchAddr = {ptrIt[31:4], 4'h0}
                      + {24'h0, 4'(ptrIt[3:0] - descLeft), 4'h0};

   // Two-entry buffer toward the link
   assign bufWr   = fetchDone && !fetchErr;
   assign bufRd   = pktValid && pktReady;
   assign pktValid = (bufCnt != 2'h0) && (state == ST_XMIT);
   assign pktData  = bufData[rdPtr];

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         bufCnt <= 2'h0;
         wrPtr  <= 1'b0;
         rdPtr  <= 1'b0;
      end
      else if (rstAny || state == ST_IDLE)
      begin
         bufCnt <= 2'h0;
         wrPtr  <= 1'b0;
         rdPtr  <= 1'b0;
      end
      else
      begin
         if (bufWr)
         begin
            wrPtr <= ~wrPtr;
         end
         if (bufRd)
         begin
            rdPtr <= ~rdPtr;
         end
         bufCnt <= 2'(bufCnt + {1'b0, bufWr} - {1'b0, bufRd});
      end
   end

   always_ff @(posedge clk)
   begin
      if (bufWr)
      begin
         bufData[wrPtr] <= fetchData;
      end
   end

endmodule // dma_context_pointer_and_iso_tx_control

// ### dma_ctx_sva.sv
`timescale 1ns/1ps
module dma_ctx_sva
   import dma_ctx_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        fetchReq,
   input wire logic [31:0] fetchAddr,
   input wire logic        fetchAck,
   input wire logic        pktValid,
   input wire logic [31:0] pktData,
   input wire logic        pktReady
);
   logic acc;
   logic ctl;
   logic hit;
   assign acc = psel && penable;
   assign ctl = paddr == ADDR_IT_SET || paddr == ADDR_IT_CLR;
   assign hit = ctl || paddr == ADDR_IT_PTR || paddr == ADDR_AREQ_PTR
      || paddr == ADDR_ARSP_PTR || paddr == ADDR_ARRQ_PTR
      || paddr == ADDR_ARRS_PTR;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   a_unmapped_err: assert property (acc && !hit |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && hit |-> !pslverr)
      else $error("mapped access refused");
   a_rsvd_zero: assert property (acc && !pwrite && ctl |->
      prdata[14:13] == 2'h0 && prdata[9:5] == 5'h00)
      else $error("reserved bits not zero");
   a_ptr_align: assert property (fetchReq |-> fetchAddr[3:0] == 4'h0)
      else $error("fetch address unaligned");
   a_fetch_hold: assert property (fetchReq && !fetchAck |=>
      fetchReq && $stable(fetchAddr)) else $error("fetch request dropped");
   a_pkt_hold: assert property (pktValid && !pktReady |=>
      pktValid && $stable(pktData)) else $error("packet word lost");
   a_run_sets: assert property (acc && pwrite && paddr == ADDR_IT_SET
      && pwdata[RUN_BIT] ##3 acc && !pwrite && ctl |-> prdata[RUN_BIT])
      else $error("run not set");
   a_run_clears: assert property (acc && pwrite && paddr == ADDR_IT_CLR
      && pwdata[RUN_BIT] ##3 acc && !pwrite && ctl
      |-> !prdata[RUN_BIT] && !prdata[DEAD_BIT]) else $error("run or halt kept");
endmodule // dma_ctx_sva

bind dma_context_pointer_and_iso_tx_control dma_ctx_sva chk_i (.clk, .sys_rst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .fetchReq,
   .fetchAddr, .fetchAck, .pktValid, .pktData, .pktReady);

// ### dma_ctx_partner.sv
`timescale 1ns/1ps
module dma_ctx_partner
(
   input  wire logic   clk,
   input  wire logic   sys_rst,
   input  wire logic   fetchReq,
   input  wire logic   failNext,
   input  wire logic   stall,
   input  wire logic   pktValid,
   output logic        fetchAck,
   output logic        fetchErr,
   output logic [31:0] fetchData,
   output logic        fetchLast,
   output logic        pktReady,
   output logic        xmitDone
);
   logic [1:0] waitCnt;
   logic       give;
   assign give = fetchReq && !fetchAck && waitCnt == 2'h2;
   assign pktReady = !stall;
   // Memory acks three cycles after the request rises; idle data toggles every cycle
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         waitCnt <= 2'h0;
         fetchAck <= 1'h0;
         fetchErr <= 1'h0;
         fetchLast <= 1'h0;
         fetchData <= 32'h0;
         xmitDone <= 1'h0;
      end
      else
      begin
         waitCnt <= (fetchReq && !fetchAck) ? waitCnt + 2'h1 : 2'h0;
         fetchAck <= give;
         fetchErr <= give && failNext;
         fetchLast <= give;
         // Single block: a zero next pointer ends the chain
         fetchData <= give ? 32'h0 : ~fetchData;
         xmitDone <= pktValid && pktReady;
      end
   end
endmodule // dma_ctx_partner

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top
   import dma_ctx_pkg::*;
;
   logic        clk = 1'h0;
   logic        sys_rst = 1'h1;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic        cycleStartSeen = 1'h0;
   logic        failNext = 1'h0;
   logic        stall = 1'h0;
   logic        pe;
   logic [11:0] paddr = 12'h000;
   logic [14:0] cycleStartValue = 15'h0000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] q;
   logic [31:0] prdata, fetchAddr, fetchData, pktData;
   logic        pready, pslverr, fetchReq, fetchAck, fetchErr, fetchLast;
   logic        pktValid, pktReady, xmitDone;
   int          error_cnt = 0;
   int          n_compared = 0;

   dma_context_pointer_and_iso_tx_control uut (.clk, .sys_rst, .softRst(1'h0),
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .fetchReq, .fetchAddr, .fetchAck, .fetchErr, .fetchData, .fetchLast,
      .cycleStartSeen, .cycleStartValue, .pktValid, .pktData, .pktReady,
      .xmitDone, .xmitDataErr(1'h0));
   dma_ctx_partner partner (.clk, .sys_rst, .fetchReq, .failNext, .stall,
      .pktValid, .fetchAck, .fetchErr, .fetchData, .fetchLast, .pktReady,
      .xmitDone);

   initial
   begin
      forever #25 clk = ~clk;
   end

   task automatic close_out();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      do @(posedge clk); while (pready !== 1'h1 && ++n < 50);
      chk("pready", 32'h1, {31'h0, pready});
      q = prdata;
      pe = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 50) close_out();
   endtask

   task automatic wait_on(input logic pkt);
      int n;
      n = 0;
      while ((pkt ? pktValid : fetchReq) !== 1'h1 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("wait", 32'h1, {31'h0, pkt ? pktValid : fetchReq});
      if (n >= 200) close_out();
   endtask

   task automatic poll();
      int n;
      n = 0;
      do apb(1'h0, ADDR_IT_SET, 32'h0);
      while (q[ACTIVE_BIT] !== 1'h0 && ++n < 100);
      chk("idle", 32'h0, {31'h0, q[ACTIVE_BIT]});
      if (n >= 100) close_out();
   endtask

   task automatic cstart(input logic [14:0] v);
      @(posedge clk);
      cycleStartSeen <= 1'h1;
      cycleStartValue <= v;
      @(posedge clk);
      cycleStartSeen <= 1'h0;
   endtask

   task automatic t_regs();
      logic [11:0] ad [5] = '{ADDR_AREQ_PTR, ADDR_ARSP_PTR, ADDR_ARRQ_PTR,
                              ADDR_ARRS_PTR, ADDR_IT_PTR};
      foreach (ad[i])
      begin
         apb(1'h1, ad[i], 32'hC3C3_0005 + 32'(i));
         apb(1'h0, ad[i], 32'h0);
         chk("ptr", 32'hC3C3_0005 + 32'(i), q);
      end
      apb(1'h0, 12'h208, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, pe});
      chk("unmapped data", 32'h0, q);
      apb(1'h1, ADDR_IT_SET, 32'h7FFF_7FFF);
      apb(1'h0, ADDR_IT_CLR, 32'h0);
      chk("ctrl set", 32'h7FFF_1000, q);
      apb(1'h1, ADDR_IT_CLR, 32'hFFFF_FFFF);
      apb(1'h0, ADDR_IT_SET, 32'h0);
      chk("ctrl clr", 32'h0, q);
   endtask

   task automatic t_run();
      stall <= 1'h1;
      apb(1'h1, ADDR_IT_PTR, 32'h0000_1231);
      apb(1'h1, ADDR_IT_SET, 32'h0000_9000);
      wait_on(1'h0);
      chk("fetch addr", 32'h0000_1230, fetchAddr);
      wait_on(1'h1);
      apb(1'h0, ADDR_IT_SET, 32'h0);
      chk("run state", 32'h21, {26'h0, q[15:10]});
      stall <= 1'h0;
      poll();
      chk("code", {27'h0, EVT_ACK_COMPLETE}, {27'h0, q[4:0]});
      apb(1'h1, ADDR_IT_CLR, 32'h0000_8000);
   endtask

   task automatic t_dead();
      failNext <= 1'h1;
      apb(1'h1, ADDR_IT_PTR, 32'h0000_2001);
      apb(1'h1, ADDR_IT_SET, 32'h0000_8000);
      poll();
      chk("halt", 32'h1, {31'h0, q[DEAD_BIT]});
      chk("code", {27'h0, EVT_DESC_READ}, {27'h0, q[4:0]});
      apb(1'h1, ADDR_IT_CLR, 32'h0000_8000);
      apb(1'h0, ADDR_IT_CLR, 32'h0);
      chk("halt clr", 32'h0, {31'h0, q[DEAD_BIT]});
      failNext <= 1'h0;
   endtask

   task automatic t_wait(input logic [31:0] ptr, input logic [31:0] ctl,
                         input logic [14:0] v, input logic req);
      logic seen;
      seen = 1'h0;
      apb(1'h1, ADDR_IT_PTR, ptr);
      apb(1'h1, ADDR_IT_SET, ctl);
      cstart(v);
      repeat (20)
      begin
         @(posedge clk);
         seen |= req ? pktValid : fetchReq;
      end
      chk("early", 32'h0, {31'h0, seen});
   endtask

   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'h0;
      t_regs();
      t_run();
      t_dead();
      t_wait(32'h0000_4001, 32'h9234_8000, 15'h1233, 1'h1);
      stall <= 1'h1;
      cstart(15'h1234);
      wait_on(1'h1);
      stall <= 1'h0;
      poll();
      apb(1'h1, ADDR_IT_CLR, 32'h0000_8000);
      t_wait(32'h0000_3000, 32'h0000_8000, 15'h0000, 1'h0);
      close_out();
   end
endmodule // tb_top
